// ### logic/ncf_framer.sv
// Purpose: Builds CAN frames for status, calendar time, packed signals and trigger events.
// Assumes: Signal values arrive already quantised with their scale factor.
// Notes:   Frames queue in a four-word FIFO ahead of the CAN controller.
`timescale 1ns/100ps
module ncf_framer #(
    parameter int STAT_CHANNELS = ncf_pkg::STAT_CHANNELS,
    parameter int FIFO_DEPTH    = ncf_pkg::FIFO_DEPTH
) (
    input  wire logic                         clk_sys_i,
    input  wire logic                         arst_n_i,
    input  wire logic                         cycle_tick_i,
    output logic [7:0]                        stat_chan_o,
    input  wire logic [ncf_pkg::DATA_W-1:0]   stat_bytes_i,
    input  wire logic                         cal_valid_i,
    output logic                              cal_ready_o,
    input  wire logic [7:0]                   year_in_century_field_i,
    input  wire logic [7:0]                   century_field_i,
    input  wire logic [7:0]                   month_field_i,
    input  wire logic [7:0]                   day_field_i,
    input  wire logic [7:0]                   hundredths_field_i,
    input  wire logic [7:0]                   seconds_field_i,
    input  wire logic [7:0]                   minutes_field_i,
    input  wire logic [7:0]                   hours_field_i,
    input  wire logic                         sig_valid_i,
    output logic                              sig_ready_o,
    input  wire logic [ncf_pkg::IDX_W-1:0]    sig_msg_idx_i,
    input  wire logic [ncf_pkg::OFS_W-1:0]    sig_offset_i,
    input  wire logic [ncf_pkg::LEN_W-1:0]    sig_len_i,
    input  wire logic                         sig_signed_i,
    input  wire logic [ncf_pkg::VAL_W-1:0]    sig_value_i,
    input  wire logic                         sig_last_i,
    input  wire logic                         trig1_i,
    input  wire logic [ncf_pkg::DATA_W-1:0]   trig_stamp_i,
    input  wire logic                         cfg_we_i,
    input  wire logic [ncf_pkg::IDX_W-1:0]    cfg_idx_i,
    input  wire logic [ncf_pkg::ID_W-1:0]     cfg_id_i,
    output logic                              cfg_err_o,
    output logic                              tx_valid_o,
    input  wire logic                         tx_ready_i,
    output logic [ncf_pkg::ID_W-1:0]          tx_id_o,
    output logic                              tx_ide_o,
    output logic [ncf_pkg::DLC_W-1:0]         tx_dlc_o,
    output logic [ncf_pkg::DATA_W-1:0]        tx_data_o
);
    import ncf_pkg::*;

    localparam logic [7:0] CHAN_LAST = 8'(STAT_CHANNELS - 1);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // ************************************************************
    // Identifier table
    // ************************************************************
    logic [ID_W-1:0] id_tab_reg [MSG_COUNT];
    logic            cfg_ok;
    logic            cfg_err_reg;

    // Writes of an analog-output identifier are refused; a status base whose channels reach them is not.
    assign cfg_ok = (cfg_idx_i < IDX_W'(MSG_COUNT)) &&
                    !((cfg_id_i >= ANA_ID_FIRST) && (cfg_id_i <= ANA_ID_LAST));

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < MSG_COUNT; i++)
                id_tab_reg[i] <= ncf_default_id(IDX_W'(i));
            cfg_err_reg <= 1'b0;
        end
        else
        begin
            cfg_err_reg <= cfg_we_i && !cfg_ok;
            if (cfg_we_i && cfg_ok)
                id_tab_reg[cfg_idx_i] <= cfg_id_i;
        end
    end
    assign cfg_err_o = cfg_err_reg;

    // ************************************************************
    // Trigger input synchroniser and edge events
    // ************************************************************
    logic [2:0] trig_sync_reg;
    logic [2:0] trig_fill_reg;
    logic       trig_level_reg;
    logic       trig_primed_reg;
    logic       trig_fall;
    logic       trig_rise;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n)
        begin
            trig_sync_reg   <= 3'h0;
            trig_fill_reg   <= 3'h0;
            trig_level_reg  <= 1'b0;
            trig_primed_reg <= 1'b0;
        end
        else
        begin
            trig_sync_reg <= {trig_sync_reg[1:0], trig1_i};
            // Priming waits until every stage holds the pin, not the reset zeros.
            trig_fill_reg <= {trig_fill_reg[1:0], 1'b1};
            if (trig_sync_reg[1] == trig_sync_reg[2])
            begin
                trig_level_reg  <= trig_sync_reg[2];
                trig_primed_reg <= trig_primed_reg || trig_fill_reg[2];
            end
        end
    end

    // The first settled level after reset only primes the detector, so no false edge.
    assign trig_fall = trig_primed_reg && (trig_sync_reg[1] == trig_sync_reg[2]) &&
                       trig_level_reg && !trig_sync_reg[2];
    assign trig_rise = trig_primed_reg && (trig_sync_reg[1] == trig_sync_reg[2]) &&
                       !trig_level_reg && trig_sync_reg[2];

    // ************************************************************
    // Signal packer
    // ************************************************************
    logic [DATA_W-1:0] pk_data_reg;
    logic [END_W-1:0]  pk_end_reg;
    logic [IDX_W-1:0]  pk_idx_reg;
    logic              pk_pend_reg;
    logic [VAL_W-1:0]  sig_fit;
    logic [95:0]       sig_shift;
    logic [END_W-1:0]  sig_end;
    logic              sig_take;

    // Out-of-range values saturate rather than wrap, so a receiver never sees a sign flip.
    function automatic logic [VAL_W-1:0] ncf_fit(input logic [VAL_W-1:0] v,
                                                 input logic [LEN_W-1:0] len,
                                                 input logic             sgn);
        logic [VAL_W-1:0] maxu;
        logic [VAL_W-1:0] maxs;
        logic [VAL_W-1:0] r;
        maxu = (VAL_W'(1) << len) - VAL_W'(1);
        maxs = (VAL_W'(1) << (len - LEN_W'(1))) - VAL_W'(1);
        r    = v;
        if (len < LEN_FULL)
        begin
            if (!sgn)
                r = (v > maxu) ? maxu : v;
            else if ($signed(v) > $signed(maxs))
                r = maxs;
            else if ($signed(v) < $signed(~maxs))
                r = ~maxs;
            r = r & maxu;
        end
        return r;
    endfunction

    assign sig_ready_o = !pk_pend_reg;
    assign sig_take    = sig_valid_i && !pk_pend_reg;
    assign sig_fit     = ncf_fit(sig_value_i, sig_len_i, sig_signed_i);
    // Raw bits go in unchanged; zero raw is zero physical, no offset is added.
    assign sig_shift   = {64'h0, sig_fit} << sig_offset_i;
    assign sig_end     = END_W'(sig_offset_i) + END_W'(sig_len_i);

    logic arb_pk;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n)
        begin
            pk_data_reg <= '0;
            pk_end_reg  <= END_ZERO;
            pk_idx_reg  <= IDX_CAL;
            pk_pend_reg <= 1'b0;
        end
        else
        begin
            if (sig_take)
            begin
                pk_data_reg <= pk_data_reg | sig_shift[DATA_W-1:0];
                pk_idx_reg  <= sig_msg_idx_i;
                if (sig_end > pk_end_reg)
                    pk_end_reg <= sig_end;
                if (sig_last_i)
                    pk_pend_reg <= 1'b1;
            end
            if (arb_pk)
            begin
                pk_data_reg <= '0;
                pk_end_reg  <= END_ZERO;
                pk_pend_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Status, calendar and trigger sources
    // ************************************************************
    logic [7:0]        chan_reg;
    logic [7:0]        st_chan_reg;
    logic [DATA_W-1:0] st_data_reg;
    logic              st_pend_reg;
    logic [DATA_W-1:0] cal_data_reg;
    logic              cal_pend_reg;
    logic [DATA_W-1:0] fall_data_reg;
    logic              fall_pend_reg;
    logic [DATA_W-1:0] rise_data_reg;
    logic              rise_pend_reg;
    logic              arb_fall;
    logic              arb_rise;
    logic              arb_st;
    logic              arb_cal;
    logic              st_load;

    // A tick that finds the previous status frame still queued is skipped, channel kept.
    assign st_load     = cycle_tick_i && (!st_pend_reg || arb_st);
    assign stat_chan_o = chan_reg;
    assign cal_ready_o = !cal_pend_reg;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n)
        begin
            chan_reg    <= 8'h00;
            st_chan_reg <= 8'h00;
            st_data_reg <= '0;
            st_pend_reg <= 1'b0;
        end
        else
        begin
            if (st_load)
            begin
                st_data_reg <= stat_bytes_i;
                st_chan_reg <= chan_reg;
                chan_reg    <= (chan_reg == CHAN_LAST) ? 8'h00 : chan_reg + 8'h01;
            end
            st_pend_reg <= st_load || (st_pend_reg && !arb_st);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n)
        begin
            cal_data_reg <= '0;
            cal_pend_reg <= 1'b0;
        end
        else
        begin
            if (cal_valid_i && !cal_pend_reg)
            begin
                // Fields are taken as given; the time source supplies GPS time.
                cal_data_reg <= {hours_field_i, minutes_field_i, seconds_field_i,
                                 hundredths_field_i, day_field_i, month_field_i,
                                 century_field_i, year_in_century_field_i};
                cal_pend_reg <= 1'b1;
            end
            else if (arb_cal)
                cal_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n)
        begin
            fall_data_reg <= '0;
            fall_pend_reg <= 1'b0;
            rise_data_reg <= '0;
            rise_pend_reg <= 1'b0;
        end
        else
        begin
            if (trig_fall)
                fall_data_reg <= trig_stamp_i;
            if (trig_rise)
                rise_data_reg <= trig_stamp_i;
            fall_pend_reg <= trig_fall || (fall_pend_reg && !arb_fall);
            rise_pend_reg <= trig_rise || (rise_pend_reg && !arb_rise);
        end
    end

    // ************************************************************
    // Arbiter into the frame queue
    // ************************************************************
    ncf_frame_if #(.W(FRAME_W)) enq_if ();
    ncf_frame_if #(.W(FRAME_W)) deq_if ();

    logic              enq_go;
    logic [ID_W-1:0]   sel_id;
    logic [DLC_W-1:0]  sel_dlc;
    logic [DATA_W-1:0] sel_data;
    logic [END_W-1:0]  pk_bytes;

    assign enq_go   = enq_if.valid && enq_if.ready;
    assign arb_fall = enq_go && fall_pend_reg;
    assign arb_rise = enq_go && !fall_pend_reg && rise_pend_reg;
    assign arb_st   = enq_go && !fall_pend_reg && !rise_pend_reg && st_pend_reg;
    assign arb_cal  = enq_go && !fall_pend_reg && !rise_pend_reg && !st_pend_reg &&
                      cal_pend_reg;
    assign arb_pk   = enq_go && !fall_pend_reg && !rise_pend_reg && !st_pend_reg &&
                      !cal_pend_reg && pk_pend_reg;
    assign pk_bytes = (pk_end_reg + END_ROUND) >> 3;

    always_comb
    begin
        sel_id   = id_tab_reg[IDX_TRIG_FALL];
        sel_dlc  = DLC_FULL;
        sel_data = fall_data_reg;
        if (fall_pend_reg)
        begin
            sel_id   = id_tab_reg[IDX_TRIG_FALL];
            sel_data = fall_data_reg;
        end
        else if (rise_pend_reg)
        begin
            sel_id   = id_tab_reg[IDX_TRIG_RISE];
            sel_data = rise_data_reg;
        end
        else if (st_pend_reg)
        begin
            sel_id   = id_tab_reg[IDX_STAT_BASE] + ID_W'(st_chan_reg);
            sel_data = st_data_reg;
        end
        else if (cal_pend_reg)
        begin
            sel_id   = id_tab_reg[IDX_CAL];
            sel_data = cal_data_reg;
        end
        else if (pk_pend_reg)
        begin
            sel_id   = id_tab_reg[pk_idx_reg];
            sel_dlc  = (pk_bytes > END_W'(DLC_FULL)) ? DLC_FULL : DLC_W'(pk_bytes);
            sel_data = pk_data_reg;
        end
    end

    assign enq_if.valid = fall_pend_reg || rise_pend_reg || st_pend_reg ||
                          cal_pend_reg || pk_pend_reg;
    assign enq_if.word  = {sel_id, sel_dlc, sel_data};

    ncf_frame_fifo #(
        .WIDTH (FRAME_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .fill      (enq_if),
        .drain     (deq_if)
    );

    // ************************************************************
    // CAN controller side
    // ************************************************************
    assign deq_if.ready = tx_ready_i;
    assign tx_valid_o   = deq_if.valid;
    assign tx_id_o      = deq_if.word[FRAME_W-1 -: ID_W];
    assign tx_dlc_o     = deq_if.word[DATA_W +: DLC_W];
    assign tx_data_o    = deq_if.word[DATA_W-1:0];
    // Only standard identifiers are produced.
    assign tx_ide_o     = 1'b0;
endmodule

// ### logic/ncf_pkg.sv
// Purpose: Shared constants for the navigation CAN message framer.
// Assumes: Standard 11-bit identifiers, up to eight payload bytes, byte 0 in the low lane.
// Notes:   The message index selects one slot of the programmable identifier table.
package ncf_pkg;

    // ************************************************************
    // Frame layout
    // ************************************************************
    localparam int ID_W    = 11;
    localparam int DLC_W   = 4;
    localparam int DATA_W  = 64;
    localparam int FRAME_W = ID_W + DLC_W + DATA_W;
    localparam int BYTE_W  = 8;
    localparam int IDX_W   = 6;
    localparam int OFS_W   = 6;
    localparam int LEN_W   = 6;
    localparam int END_W   = 7;
    localparam int VAL_W   = 32;
    localparam int CAL_FIELDS = 8;

    localparam logic [DLC_W-1:0] DLC_FULL = 4'h8;
    localparam logic [END_W-1:0] END_ZERO = 7'h00;
    localparam logic [END_W-1:0] END_ROUND = 7'h07;
    localparam logic [LEN_W-1:0] LEN_FULL = 6'h20;
    localparam int FIFO_DEPTH = 4;
    localparam int STAT_CHANNELS = 256;
    // Informative only: the calendar fields run on GPS time, this far ahead of UTC.
    localparam int GPS_UTC_OFFSET_S = 16;

    // ************************************************************
    // Default identifier map
    // ************************************************************
    localparam logic [ID_W-1:0] STAT_ID_BASE  = 11'h500;
    localparam logic [ID_W-1:0] NAV_ID_FIRST  = 11'h600;
    localparam logic [ID_W-1:0] ANA_ID_FIRST  = 11'h610;
    localparam logic [ID_W-1:0] ANA_ID_LAST   = 11'h613;
    localparam logic [ID_W-1:0] POINT_ID_FIRST = 11'h620;
    localparam logic [ID_W-1:0] TRIG_ID_FIRST = 11'h62d;
    localparam logic [ID_W-1:0] ISO_ID_FIRST  = 11'h633;

    // ************************************************************
    // Identifier table slots
    // ************************************************************
    localparam logic [IDX_W-1:0] IDX_CAL        = 6'h00;
    localparam logic [IDX_W-1:0] IDX_NAV_LAST   = 6'h0f;
    localparam logic [IDX_W-1:0] IDX_POINT_FIRST = 6'h10;
    localparam logic [IDX_W-1:0] IDX_POINT_LAST = 6'h1b;
    localparam logic [IDX_W-1:0] IDX_TRIG_FALL  = 6'h1c;
    localparam logic [IDX_W-1:0] IDX_TRIG_RISE  = 6'h1d;
    localparam logic [IDX_W-1:0] IDX_TRIG_LAST  = 6'h1f;
    localparam logic [IDX_W-1:0] IDX_ISO_FIRST  = 6'h20;
    localparam logic [IDX_W-1:0] IDX_ISO_LAST   = 6'h2a;
    localparam logic [IDX_W-1:0] IDX_STAT_BASE  = 6'h2b;
    localparam int MSG_COUNT = 44;

    function automatic logic [ID_W-1:0] ncf_default_id(input logic [IDX_W-1:0] idx);
        logic [ID_W-1:0] id;
        id = STAT_ID_BASE;
        if (idx <= IDX_NAV_LAST)
            id = NAV_ID_FIRST + ID_W'(idx);
        else if (idx <= IDX_POINT_LAST)
            id = POINT_ID_FIRST + ID_W'(idx - IDX_POINT_FIRST);
        else if (idx <= IDX_TRIG_LAST)
            id = TRIG_ID_FIRST + ID_W'(idx - IDX_TRIG_FALL);
        else if (idx <= IDX_ISO_LAST)
            id = ISO_ID_FIRST + ID_W'(idx - IDX_ISO_FIRST);
        return id;
    endfunction

endpackage

// ### logic/ncf_frame_if.sv
// Purpose: Valid/ready carrier for one queued CAN frame word.
// Assumes: Word is {identifier, length code, payload}.
// Notes:   A transfer happens on a clock edge where valid and ready are both high.
`timescale 1ns/100ps
interface ncf_frame_if #(parameter int W = ncf_pkg::FRAME_W);
    logic         valid;
    logic         ready;
    logic [W-1:0] word;

    modport src (output valid, output word, input ready);
    modport snk (input valid, input word, output ready);
endinterface

// ### logic/ncf_frame_fifo.sv
// Purpose: Small flip-flop FIFO between the frame builder and the CAN controller.
// Assumes: One clock, synchronous active-low reset already released cleanly.
// Notes:   Ready on the fill side drops when full, stalling the builder.
`timescale 1ns/100ps
module ncf_frame_fifo #(
    parameter int WIDTH = ncf_pkg::FRAME_W,
    parameter int DEPTH = ncf_pkg::FIFO_DEPTH
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    ncf_frame_if.snk  fill,
    ncf_frame_if.src  drain
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic             push;
    logic             pop;

    assign fill.ready  = (count_reg != CNT_FULL);
    assign drain.valid = (count_reg != '0);
    assign drain.word  = mem_reg[rd_ptr_reg];
    assign push        = fill.valid && fill.ready;
    assign pop         = drain.valid && drain.ready;

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= fill.word;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PTR_W'(1);
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PTR_W'(1);
            if (push && !pop)
                count_reg <= count_reg + CNT_W'(1);
            else if (pop && !push)
                count_reg <= count_reg - CNT_W'(1);
        end
    end
endmodule

// ### bench/ncf_framer_monitor.sv
// Purpose: Port-level checks of the CAN frame builder.
// Assumes: One clock; stimulus changes just after the rising edge.
// Notes:   Bound into every framer instance.
`timescale 1ns/100ps
module ncf_framer_monitor #(
    parameter int STAT_CHANNELS = 256
) (
    input wire logic        clk_sys_i,
    input wire logic        arst_n_i,
    input wire logic        cycle_tick_i,
    input wire logic [7:0]  stat_chan_o,
    input wire logic        cal_valid_i,
    input wire logic        cal_ready_o,
    input wire logic        sig_valid_i,
    input wire logic        sig_ready_o,
    input wire logic        sig_last_i,
    input wire logic        cfg_we_i,
    input wire logic [5:0]  cfg_idx_i,
    input wire logic [10:0] cfg_id_i,
    input wire logic        cfg_err_o,
    input wire logic        tx_valid_o,
    input wire logic        tx_ready_i,
    input wire logic [10:0] tx_id_o,
    input wire logic        tx_ide_o,
    input wire logic [3:0]  tx_dlc_o,
    input wire logic [63:0] tx_data_o
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_bad_cfg;
        cfg_we_i && (cfg_idx_i > 6'h2b || (cfg_id_i >= 11'h610 && cfg_id_i <= 11'h613));
    endsequence
    sequence s_held;
        tx_valid_o && $stable(tx_id_o) && $stable(tx_dlc_o) && $stable(tx_data_o);
    endsequence
    a_refuse_bad_cfg: assert property (s_bad_cfg |=> cfg_err_o)
        else $error("refused write gave no error pulse");
    a_accept_good_cfg: assert property (cfg_we_i && cfg_idx_i <= 6'h2b &&
        !(cfg_id_i >= 11'h610 && cfg_id_i <= 11'h613) |=> !cfg_err_o)
        else $error("legal table write flagged");
    a_err_has_cause: assert property (cfg_err_o |-> $past(cfg_we_i))
        else $error("error pulse without a write");
    a_frame_standard: assert property (tx_valid_o |-> !tx_ide_o && tx_dlc_o inside {[1:8]})
        else $error("frame not standard or bad length");
    a_no_analog_id: assert property (tx_valid_o |-> !(tx_id_o inside {[11'h610:11'h613]}))
        else $error("frame on analog output identifier");
    a_frame_held: assert property (tx_valid_o && !tx_ready_i |=> s_held)
        else $error("offered frame changed before taken");
    a_chan_step: assert property ($changed(stat_chan_o) |-> $past(cycle_tick_i)
        && stat_chan_o == ($past(stat_chan_o) + 1) % STAT_CHANNELS)
        else $error("status channel moved wrongly");
    a_cal_taken: assert property (cal_valid_i && cal_ready_o |=> !cal_ready_o)
        else $error("calendar still ready after take");
    a_sig_closed: assert property (sig_valid_i && sig_ready_o && sig_last_i |=> !sig_ready_o)
        else $error("signal port ready after last signal");
endmodule

bind ncf_framer ncf_framer_monitor #(.STAT_CHANNELS(STAT_CHANNELS)) u_mon (.*);

// ### bench/ncf_can_sink.sv
// Purpose: CAN controller model that takes queued frames.
// Assumes: Frame taken on an edge with valid and ready high.
// Notes:   Stall holds ready low so the queue backs up.
`timescale 1ns/100ps
module ncf_can_sink (
    input  wire logic        clk_sys_i,
    input  wire logic        stall_i,
    input  wire logic        valid_i,
    input  wire logic [10:0] id_i,
    input  wire logic [3:0]  dlc_i,
    input  wire logic [63:0] data_i,
    output logic             ready_o
);
    logic [78:0] rx_q[$];
    assign ready_o = !stall_i;
    // Raw payload is kept; scaling by the signal factor is left to the reader.
    always @(posedge clk_sys_i)
        if (valid_i && ready_o) rx_q.push_back({id_i, dlc_i, data_i});
endmodule

// ### bench/ncf_framer_tb_top.sv
// Purpose: Self-checking bench for the CAN frame builder.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Expected frames are built here from the identifier map.
`timescale 1ns/100ps
module ncf_framer_tb_top;
    logic clk_sys_i = 0, arst_n_i = 0, cycle_tick_i = 0, cal_valid_i = 0, sig_valid_i = 0;
    logic sig_signed_i = 0, sig_last_i = 0, trig1_i = 1, cfg_we_i = 0, stall = 0;
    logic [7:0] stat_chan_o, year_in_century_field_i = 0, century_field_i = 0;
    logic [7:0] month_field_i = 0, day_field_i = 0, hundredths_field_i = 0;
    logic [7:0] seconds_field_i = 0, minutes_field_i = 0, hours_field_i = 0;
    logic [63:0] stat_bytes_i = 0, trig_stamp_i = 0, tx_data_o;
    logic [5:0] sig_msg_idx_i = 0, sig_offset_i = 0, sig_len_i = 0, cfg_idx_i = 0;
    logic [31:0] sig_value_i = 0;
    logic [10:0] cfg_id_i = 0, tx_id_o;
    logic [3:0] tx_dlc_o;
    logic cal_ready_o, sig_ready_o, cfg_err_o, tx_valid_o, tx_ready_i, tx_ide_o;
    int error_cnt = 0, samples_checked = 0, chan = 0;
    ncf_framer DUT (.*);
    ncf_can_sink CAN (.clk_sys_i(clk_sys_i), .stall_i(stall), .valid_i(tx_valid_o),
        .id_i(tx_id_o), .dlc_i(tx_dlc_o), .data_i(tx_data_o), .ready_o(tx_ready_i));
    // ************************************************************
    // Helpers and scenarios
    // ************************************************************
    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic cmp(input logic [78:0] got, input logic [78:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic expect_frame(input logic [10:0] id, input logic [3:0] dlc,
                                input logic [63:0] data);
        logic [78:0] f;
        f = 'x;
        repeat (60) if (CAN.rx_q.size() == 0) step(1);
        if (CAN.rx_q.size() != 0) f = CAN.rx_q.pop_front();
        cmp(f, {id, dlc, data});
    endtask
    task automatic cfg(input logic [5:0] idx, input logic [10:0] id, input logic err);
        cfg_we_i = 1;
        cfg_idx_i = idx;
        cfg_id_i = id;
        step(1);
        cfg_we_i = 0;
        cmp(cfg_err_o, err);
        step(1);
    endtask
    task automatic cal(input logic [10:0] id);
        {hours_field_i, minutes_field_i, seconds_field_i, hundredths_field_i, day_field_i,
         month_field_i, century_field_i, year_in_century_field_i} = 64'h173b3b63_1f0c1418;
        cal_valid_i = 1;
        while (cal_ready_o !== 1'b1) step(1);
        step(1);
        cal_valid_i = 0;
        expect_frame(id, 4'h8, 64'h173b3b63_1f0c1418);
    endtask
    task automatic sig(input logic [5:0] idx, ofs, len, input logic sg,
                       input logic [31:0] v, input logic last);
        {sig_msg_idx_i, sig_offset_i, sig_len_i, sig_signed_i} = {idx, ofs, len, sg};
        {sig_value_i, sig_last_i, sig_valid_i} = {v, last, 1'b1};
        while (sig_ready_o !== 1'b1) step(1);
        step(1);
        sig_valid_i = 0;
        step(1);
    endtask
    task automatic tick(input int k);
        stat_bytes_i = 64'h07060504_03020100 + 64'(k);
        cycle_tick_i = 1;
        step(1);
        cycle_tick_i = 0;
        step(3);
    endtask
    task automatic test_defaults;
        logic [5:0] ix [10] = '{2, 15, 16, 19, 21, 24, 25, 27, 32, 42};
        logic [10:0] dv [10] = '{11'h602, 11'h60f, 11'h620, 11'h623, 11'h625,
                                 11'h628, 11'h629, 11'h62b, 11'h633, 11'h63d};
        for (int k = 0; k < 10; k++)
        begin
            sig(ix[k], 6'h00, 6'h08, 0, 32'(k), 1);
            expect_frame(dv[k], 4'h1, 64'(k));
        end
        $display("test_defaults done");
    endtask
    task automatic test_stat_fifo;
        tick(0);
        expect_frame(11'h500, 4'h8, 64'h07060504_03020100);
        chan = 1;
        stall = 1;
        for (int k = 0; k < 6; k++) tick(k);
        stall = 0;
        for (int k = 0; k < 5; k++)
            expect_frame(11'h501 + 11'(k), 4'h8, 64'h07060504_03020100 + 64'(k));
        chan += 5;
        cmp(stat_chan_o, 79'(chan));
        $display("test_stat_fifo done");
    endtask
    initial
    begin
        step(12);
        arst_n_i = 1;
        step(3);
        cfg(6'h00, 11'h611, 1);
        cfg(6'h2c, 11'h700, 1);
        cfg(6'h00, 11'h7f0, 0);
        cal(11'h7f0);
        cfg(6'h00, 11'h600, 0);
        cal(11'h600);
        sig(6'h01, 6'h00, 6'h10, 1, 32'hfffffffb, 0);
        sig(6'h01, 6'h10, 6'h10, 0, 32'h00001234, 0);
        sig(6'h01, 6'h20, 6'h08, 0, 32'h0, 1);
        expect_frame(11'h601, 4'h5, 64'h00_1234_fffb);
        test_defaults();
        trig_stamp_i = 64'h0123_4567_89ab_cdef;
        trig1_i = 0;
        expect_frame(11'h62d, 4'h8, trig_stamp_i);
        trig1_i = 1;
        expect_frame(11'h62e, 4'h8, trig_stamp_i);
        test_stat_fifo();
        complete_run();
    end
    initial
    begin
        #200000;
        error_cnt++;
        complete_run();
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
endmodule
